// file: swsc_pkg.sv
// shared constants, types and timing for the single-wire slave sequencer
package swsc_pkg;
  // clock rate and bus timing, times in microseconds
  localparam int CLK_MHZ            = 250;
  localparam int T_RST_DET_US       = 16;   // low longer than this is a reset
  localparam int T_PRES_WAIT_US     = 2;    // rising edge to presence start
  localparam int T_PRES_LOW_US      = 10;   // presence pulse length
  localparam int T_SAMPLE_US        = 4;    // write slot sample point
  localparam int T_READ_HOLD_US     = 3;    // read-zero pulldown length
  localparam int POWER_UP_WAIT_US   = 2000; // spontaneous presence ends before
  localparam int T_PU_PRES_US       = POWER_UP_WAIT_US / 2;
  localparam int RST_DET_CYC   = T_RST_DET_US * CLK_MHZ;
  localparam int PRES_WAIT_CYC = T_PRES_WAIT_US * CLK_MHZ;
  localparam int PRES_LOW_CYC  = T_PRES_LOW_US * CLK_MHZ;
  localparam int SAMPLE_CYC    = T_SAMPLE_US * CLK_MHZ;
  localparam int READ_HOLD_CYC = T_READ_HOLD_US * CLK_MHZ;
  localparam int PU_PRES_CYC   = T_PU_PRES_US * CLK_MHZ;
  // selection command codes
  localparam logic [7:0] ROM_SEARCH = 8'hF0;
  localparam logic [7:0] ROM_READ   = 8'h33;
  localparam logic [7:0] ROM_MATCH  = 8'h55;
  localparam logic [7:0] ROM_SKIP   = 8'hCC;
  localparam logic [7:0] ROM_RESUME = 8'hA5;
  // function stage codes
  localparam logic [7:0] CMD_START   = 8'h66;
  localparam logic [7:0] FN_WRITE    = 8'h01;
  localparam logic [7:0] FN_DEC      = 8'h02;
  localparam logic [7:0] FN_READ     = 8'h03;
  localparam logic [7:0] FN_PROTECT  = 8'h04;
  localparam logic [7:0] STS_OK      = 8'hAA;
  localparam logic [7:0] STS_FAIL    = 8'h55;
  localparam logic [7:0] STS_CRC_ERR = 8'h33;
  localparam logic [15:0] CRC_POLY   = 16'hA001;
  localparam logic [15:0] CRC_INIT   = 16'h0000;
  localparam logic [16:0] CNT_RESET  = 17'h00000;
  localparam logic [7:0]  PROT_RESET = 8'h00;
  typedef enum logic [3:0] {
    P_IDLE, P_ROM, P_SEARCH, P_READROM, P_MATCH, P_START,
    P_CMD, P_PARAM, P_CRC_IN, P_EXEC, P_REPLY
  } swsc_phase_t;
  // counter page seen from outside
  typedef struct packed {
    logic        written;
    logic [16:0] value;
  } swsc_cnt_t;
endpackage

// file: swsc_top.sv
// single-wire slave sequencer with decrement-only counter and reply fifo
`timescale 1ns/1ps
`default_nettype none

module swsc_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0]         wp;
    logic [AW:0]         rp;
  } swsc_fifo_st_t;
  swsc_fifo_st_t r_reg, r_next;
  logic full, empty;

  // extra pointer bit tells full from empty
  assign empty     = (r_reg.wp == r_reg.rp);
  assign full      = (r_reg.wp[AW-1:0] == r_reg.rp[AW-1:0]) && !empty;
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = r_reg.mem[r_reg.rp[AW-1:0]];

  always_comb begin
    r_next = r_reg;
    if (in_valid && !full) begin
      r_next.mem[r_reg.wp[AW-1:0]] = in_data;
      r_next.wp = r_reg.wp + 1'b1;
    end
    if (out_ready && !empty) begin
      r_next.rp = r_reg.rp + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule

// Functional notes
// - function stage opens only after reset, presence and a selection command
// - command, parameters and reply carry a 16-bit crc checked by receiver
// - 17-bit counter on its page may be written once only
// - each decrement command on a written, nonzero counter with good crc lowers it by exactly one
// - counter at zero refuses decrement; it never wraps
// - single master; this end only answers, never starts a slot
// - every slot is timed from the master's falling edge
// - spontaneous presence pulse after power-up, finished within 2 ms
// - counter page has fixed write-once mode; user mode byte is settable
// - order is reset/presence, selection, function command, data
// - five 8-bit selection commands: search, read, match, skip, resume
module swsc_top #(
  parameter int          PU_CYC = swsc_pkg::PU_PRES_CYC,
  parameter logic [63:0] ROM_ID = 64'h0123456789ABCDEF // arbitrary value
) (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              line_in,
  output logic                   line_out,
  output logic                   line_oe,
  output swsc_pkg::swsc_cnt_t    counter_state,
  output logic                   selected
);
  typedef struct packed {
    logic                  s1, s2, prev;
    logic [11:0]           low_cnt;
    logic [11:0]           tcnt;
    logic [19:0]           pu_cnt;
    logic                  pu_done, rst_seen, pres_on, slot, drive, rc;
    swsc_pkg::swsc_phase_t phase;
    logic [6:0]            bitcnt;
    logic [1:0]            sub;
    logic [63:0]           sh;
    logic [7:0]            rx, cmd, status, prot;
    logic [23:0]           prm;
    logic [1:0]            pcnt;
    logic [15:0]           crc, rcrc;
    logic [2:0]            ecnt;
    swsc_pkg::swsc_cnt_t   cnt;
  } swsc_st_t;
  swsc_st_t r_reg, r_next;

  logic       f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [7:0] f_in_data, f_out_data;

  function automatic logic [15:0] crc16_byte(input logic [15:0] c,
                                             input logic [7:0]  d);
    logic [15:0] x;
    x = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ swsc_pkg::CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction

  swsc_fifo #(.W(8), .D(16)) u_reply_fifo (
    .clk       (sys_clk),
    .resetn    (resetn),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // open drain: the pin is only ever pulled low
  assign line_out      = 1'b0;
  assign line_oe       = r_reg.drive;
  assign counter_state = r_reg.cnt;
  assign selected      = r_reg.rc;

  always_comb begin
    logic       fall, rise, b, tx_slot, tx_bit, bdone;
    logic [7:0] nb, eb;
    logic [2:0] nd;
    r_next      = r_reg;
    f_in_valid  = 1'b0;
    f_in_data   = 8'h00;
    f_out_ready = 1'b0;
    fall   = r_reg.prev & ~r_reg.s2;
    rise   = ~r_reg.prev & r_reg.s2;
    b      = r_reg.s2;
    nb     = {b, r_reg.rx[7:1]};
    bdone  = (r_reg.bitcnt[2:0] == 3'd7);
    eb     = 8'h00;
    nd     = 3'd1;
    tx_slot = 1'b0;
    tx_bit  = 1'b1;
    // pin passes two flops before anything looks at it
    r_next.s1   = line_in;
    r_next.s2   = r_reg.s1;
    r_next.prev = r_reg.s2;
    // which slots this end answers, and with what bit
    tx_slot = (r_reg.phase == swsc_pkg::P_READROM) ||
              (r_reg.phase == swsc_pkg::P_REPLY) ||
              (r_reg.phase == swsc_pkg::P_SEARCH && r_reg.sub != 2'd2);
    case (r_reg.phase)
      swsc_pkg::P_READROM: tx_bit = r_reg.sh[0];
      swsc_pkg::P_SEARCH:  tx_bit = r_reg.sh[0] ^ r_reg.sub[0];
      swsc_pkg::P_REPLY:
        tx_bit = f_out_valid ? f_out_data[r_reg.bitcnt[2:0]] : 1'b1;
      default:             tx_bit = 1'b1;
    endcase
    // long low from the master is a bus reset
    r_next.low_cnt = r_reg.s2 ? 12'h000 : r_reg.low_cnt + 12'h001;
    if (!r_reg.s2 && !r_reg.drive &&
        r_reg.low_cnt == 12'(swsc_pkg::RST_DET_CYC - 1)) begin
      r_next.rst_seen = 1'b1;
      r_next.slot     = 1'b0;
      r_next.phase    = swsc_pkg::P_IDLE;
    end
    // spontaneous presence once after power-up
    if (!r_reg.pu_done) begin
      r_next.pu_cnt = r_reg.pu_cnt + 20'h00001;
      if (r_reg.pu_cnt == 20'(PU_CYC - 1)) begin
        r_next.pu_done = 1'b1;
        r_next.pres_on = 1'b1;
        r_next.tcnt    = 12'h000;
      end
    end
    if (rise && r_reg.rst_seen) begin
      // presence answers the reset, then selection commands follow
      r_next.rst_seen = 1'b0;
      r_next.pres_on  = 1'b1;
      r_next.tcnt     = 12'h000;
      r_next.phase    = swsc_pkg::P_ROM;
      r_next.bitcnt   = 7'd0;
    end else if (r_reg.pres_on) begin
      r_next.tcnt = r_reg.tcnt + 12'h001;
      if (r_reg.tcnt == 12'(swsc_pkg::PRES_WAIT_CYC - 1)) begin
        r_next.drive = 1'b1;
      end
      if (r_reg.tcnt == 12'(swsc_pkg::PRES_WAIT_CYC +
                            swsc_pkg::PRES_LOW_CYC - 1)) begin
        r_next.drive   = 1'b0;
        r_next.pres_on = 1'b0;
      end
    end else if (fall && !r_reg.slot && !r_reg.drive) begin
      // slave only: a slot exists only after the master's edge
      r_next.slot  = 1'b1;
      r_next.tcnt  = 12'h000;
      r_next.drive = tx_slot && !tx_bit;
    end else if (r_reg.slot) begin
      r_next.tcnt = r_reg.tcnt + 12'h001;
      if (r_reg.tcnt == 12'(swsc_pkg::READ_HOLD_CYC - 1)) begin
        r_next.drive = 1'b0;
      end
      if (r_reg.tcnt == 12'(swsc_pkg::SAMPLE_CYC - 1)) begin
        r_next.slot   = 1'b0;
        r_next.rx     = nb;
        r_next.bitcnt = r_reg.bitcnt + 7'd1;
        case (r_reg.phase)
          swsc_pkg::P_ROM: if (bdone) begin
            r_next.sh     = ROM_ID;
            r_next.bitcnt = 7'd0;
            r_next.sub    = 2'd0;
            case (nb)
              swsc_pkg::ROM_SEARCH: r_next.phase = swsc_pkg::P_SEARCH;
              swsc_pkg::ROM_READ:   r_next.phase = swsc_pkg::P_READROM;
              swsc_pkg::ROM_MATCH:  r_next.phase = swsc_pkg::P_MATCH;
              swsc_pkg::ROM_SKIP: begin
                r_next.phase = swsc_pkg::P_START;
                r_next.rc    = 1'b0;
              end
              swsc_pkg::ROM_RESUME:
                r_next.phase = r_reg.rc ? swsc_pkg::P_START : swsc_pkg::P_IDLE;
              default: r_next.phase = swsc_pkg::P_IDLE;
            endcase
          end
          swsc_pkg::P_READROM: begin
            r_next.sh = {1'b0, r_reg.sh[63:1]};
            if (r_reg.bitcnt == 7'd63) begin
              r_next.phase = swsc_pkg::P_START;
              r_next.rc    = 1'b1;
            end
          end
          swsc_pkg::P_MATCH, swsc_pkg::P_SEARCH: begin
            // search: bit, its complement, then the master's choice
            if (r_reg.phase == swsc_pkg::P_SEARCH && r_reg.sub != 2'd2) begin
              r_next.sub    = r_reg.sub + 2'd1;
              r_next.bitcnt = r_reg.bitcnt;
            end else if (b != r_reg.sh[0]) begin
              r_next.phase = swsc_pkg::P_IDLE;
              r_next.rc    = 1'b0;
            end else begin
              r_next.sub = 2'd0;
              r_next.sh  = {1'b0, r_reg.sh[63:1]};
              if (r_reg.bitcnt == 7'd63) begin
                r_next.phase = swsc_pkg::P_START;
                r_next.rc    = 1'b1;
              end
            end
          end
          swsc_pkg::P_START: if (bdone) begin
            r_next.phase = (nb == swsc_pkg::CMD_START) ?
                           swsc_pkg::P_CMD : swsc_pkg::P_IDLE;
          end
          swsc_pkg::P_CMD: if (bdone) begin
            r_next.cmd = nb;
            // crc field counts its 16 bits from zero, whatever came before
            r_next.bitcnt = 7'd0;
            r_next.crc = crc16_byte(swsc_pkg::CRC_INIT, nb);
            r_next.prm = 24'h000000;
            r_next.phase = swsc_pkg::P_PARAM;
            case (nb)
              swsc_pkg::FN_WRITE:   r_next.pcnt = 2'd3;
              swsc_pkg::FN_PROTECT: r_next.pcnt = 2'd1;
              swsc_pkg::FN_DEC, swsc_pkg::FN_READ:
                r_next.phase = swsc_pkg::P_CRC_IN;
              default: r_next.phase = swsc_pkg::P_IDLE;
            endcase
          end
          swsc_pkg::P_PARAM: if (bdone) begin
            r_next.prm  = {nb, r_reg.prm[23:8]};
            r_next.crc  = crc16_byte(r_reg.crc, nb);
            r_next.pcnt = r_reg.pcnt - 2'd1;
            if (r_reg.pcnt == 2'd1) begin
              r_next.phase  = swsc_pkg::P_CRC_IN;
              r_next.bitcnt = 7'd0;
            end
          end
          swsc_pkg::P_CRC_IN: begin
            r_next.rcrc = {b, r_reg.rcrc[15:1]};
            if (r_reg.bitcnt == 7'd15) begin
              // act only on a checked command; then the reply
              r_next.phase  = swsc_pkg::P_EXEC;
              r_next.ecnt   = 3'd0;
              r_next.status = swsc_pkg::STS_OK;
              if ({b, r_reg.rcrc[15:1]} != r_reg.crc) begin
                r_next.status = swsc_pkg::STS_CRC_ERR;
              end else begin
                case (r_reg.cmd)
                  swsc_pkg::FN_WRITE:
                    if (r_reg.cnt.written || r_reg.prot[0]) begin
                      r_next.status = swsc_pkg::STS_FAIL;
                    end else begin
                      r_next.cnt.value   = r_reg.prm[23:7];
                      r_next.cnt.written = 1'b1;
                    end
                  swsc_pkg::FN_DEC:
                    if (!r_reg.cnt.written ||
                        r_reg.cnt.value == 17'h00000) begin
                      r_next.status = swsc_pkg::STS_FAIL;
                    end else begin
                      r_next.cnt.value = r_reg.cnt.value - 17'h00001;
                    end
                  swsc_pkg::FN_PROTECT:
                    if (r_reg.prot != swsc_pkg::PROT_RESET) begin
                      r_next.status = swsc_pkg::STS_FAIL;
                    end else begin
                      r_next.prot = r_reg.prm[23:16];
                    end
                  default: ;
                endcase
              end
            end
          end
          swsc_pkg::P_REPLY: begin
            // empty fifo means the reply is over
            if (!f_out_valid) begin
              r_next.phase = swsc_pkg::P_IDLE;
            end else if (bdone) begin
              f_out_ready = 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
    // drop bytes left by a cut reply so they never lead a later one
    if (r_reg.phase != swsc_pkg::P_EXEC &&
        r_reg.phase != swsc_pkg::P_REPLY) begin
      f_out_ready = 1'b1;
    end
    // reply bytes: status, counter for a read, crc low, crc high
    if (r_reg.phase == swsc_pkg::P_EXEC) begin
      if (r_reg.cmd == swsc_pkg::FN_READ &&
          r_reg.status == swsc_pkg::STS_OK) begin
        nd = 3'd4;
      end
      if (r_reg.ecnt == 3'd0) begin
        eb = r_reg.status;
      end else if (r_reg.ecnt < nd) begin
        eb = 8'({7'h00, r_reg.cnt.value} >> (8 * (r_reg.ecnt - 3'd1)));
      end else if (r_reg.ecnt == nd) begin
        eb = r_reg.crc[7:0];
      end else begin
        eb = r_reg.crc[15:8];
      end
      f_in_valid = 1'b1;
      f_in_data  = eb;
      // a full fifo stalls the reply builder
      if (f_in_ready) begin
        r_next.ecnt = r_reg.ecnt + 3'd1;
        if (r_reg.ecnt < nd) begin
          r_next.crc = crc16_byte(r_reg.ecnt == 3'd0 ?
                                  swsc_pkg::CRC_INIT : r_reg.crc, eb);
        end
        if (r_reg.ecnt == nd + 3'd1) begin
          r_next.phase  = swsc_pkg::P_REPLY;
          r_next.bitcnt = 7'd0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      r_reg       <= '0;
      r_reg.s1    <= 1'b1;
      r_reg.s2    <= 1'b1;
      r_reg.prev  <= 1'b1;
      r_reg.phase <= swsc_pkg::P_IDLE;
      r_reg.cnt   <= '{written: 1'b0, value: swsc_pkg::CNT_RESET};
      r_reg.prot  <= swsc_pkg::PROT_RESET;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule

`default_nettype wire

// file: swsc_monitor.sv
// port checker for the single-wire slave sequencer
`timescale 1ns/1ps
`default_nettype none
module swsc_monitor #(
  parameter int PU_CYC = swsc_pkg::PU_PRES_CYC
) (
  input wire logic                sys_clk,
  input wire logic                resetn,
  input wire logic                line_in,
  input wire logic                line_out,
  input wire logic                line_oe,
  input wire swsc_pkg::swsc_cnt_t counter_state,
  input wire logic                selected
);
  localparam int PU_LIM = PU_CYC + swsc_pkg::PRES_WAIT_CYC + 20;
  logic [17:0] hi_reg;
  logic [17:0] oe_reg;
  logic [17:0] up_reg;
  logic        seen_reg;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // run lengths of bus high, own drive and time since reset release
  always_ff @(posedge sys_clk) begin
    hi_reg   <= (!resetn || !line_in) ? 18'h0 : hi_reg + 18'h1;
    oe_reg   <= (!resetn || !line_oe) ? 18'h0 : oe_reg + 18'h1;
    up_reg   <= !resetn ? 18'h0 : up_reg + {17'h0, up_reg != 18'h3FFFF};
    seen_reg <= resetn && (seen_reg || line_oe);
  end
  // first drive after reset is the spontaneous presence
  sequence s_first_drive;
    $rose(line_oe) && !seen_reg;
  endsequence
  AST_OPEN_DRAIN: assert property (line_out == 1'b0)
    else $error("pin output value not low");
  // a drive starts either right after a master fall or after a long high
  AST_RISE_CAUSE: assert property ($rose(line_oe) |->
    hi_reg == 18'h0 || hi_reg >= 18'(swsc_pkg::PRES_WAIT_CYC - 10))
    else $error("drive started in mid slot");
  AST_DRIVE_LEN: assert property ($fell(line_oe) |->
    oe_reg == 18'(swsc_pkg::READ_HOLD_CYC) ||
    oe_reg == 18'(swsc_pkg::PRES_LOW_CYC))
    else $error("drive length wrong");
  AST_PU_EARLY: assert property (s_first_drive |->
    up_reg >= 18'(PU_LIM - 40))
    else $error("power-up presence too early");
  AST_PU_DUE: assert property (up_reg == 18'(PU_LIM) |-> seen_reg)
    else $error("power-up presence missing");
  AST_DEC_BY_ONE: assert property (
    $changed(counter_state) && $past(counter_state.written) |->
    counter_state.value == $past(counter_state.value) - 17'h1)
    else $error("written counter moved by other than one");
  AST_NO_WRAP: assert property (
    $past(counter_state.written) && $past(counter_state.value) == 17'h0
    |-> counter_state.value == 17'h0)
    else $error("counter left zero");
  AST_WRITE_ONCE: assert property (
    $past(counter_state.written) |-> counter_state.written)
    else $error("written flag cleared");
  // selection completes at a slot's sample point, never while we pull low
  AST_SEL_RISE: assert property ($rose(selected) |-> !line_oe)
    else $error("selection flag set while pin driven");
  AST_UNWRITTEN: assert property (
    !counter_state.written |-> counter_state.value == swsc_pkg::CNT_RESET)
    else $error("unwritten counter not at reset value");
endmodule
`default_nettype wire

// file: swsc_master.sv
// bus master model on the shared open-drain line with pull-up
`timescale 1ns/1ps
`default_nettype none
module swsc_master (
  input  wire logic sys_clk,
  input  wire logic line_oe,
  output wire logic bus_line
);
  // shortened figures: the block only needs its own thresholds met
  localparam int RST_LOW  = 4500;
  localparam int RST_HIGH = 3500;
  localparam int PRES_SMP = 2000;
  localparam int W0_LOW   = 1100;
  localparam int W1_LOW   = 75;
  localparam int R_LOW    = 75;
  localparam int R_SMP    = 400;
  localparam int SLOT     = 1250;
  logic drv_low = 1'b0;
  // line is low whenever either party pulls it, else pulled high
  assign bus_line = !(drv_low || line_oe);
  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // reset, look for presence, then sit out the high interval
  task automatic bus_reset(output logic pres);
    drv_low = 1'b1;
    hold(RST_LOW);
    drv_low = 1'b0;
    hold(PRES_SMP);
    pres = !bus_line;
    hold(RST_HIGH - PRES_SMP);
  endtask
  // every slot opens with our own falling edge; the device only answers
  task automatic wbit(input logic b);
    drv_low = 1'b1;
    hold(b ? W1_LOW : W0_LOW);
    drv_low = 1'b0;
    hold(b ? SLOT - W1_LOW : SLOT - W0_LOW);
  endtask
  task automatic rbit(output logic b);
    drv_low = 1'b1;
    hold(R_LOW);
    drv_low = 1'b0;
    hold(R_SMP - R_LOW);
    b = bus_line;
    hold(SLOT - R_SMP);
  endtask
  task automatic wbyte(input logic [7:0] d);
    for (int i = 0; i < 8; i++) wbit(d[i]);
  endtask
  task automatic rbyte(output logic [7:0] d);
    for (int i = 0; i < 8; i++) rbit(d[i]);
  endtask
endmodule
`default_nettype wire

// file: swsc_top_tb.sv
// self-checking bench for the single-wire slave sequencer
`timescale 1ns/1ps
`default_nettype none
module swsc_top_tb;
  localparam int          PU_CYC = 2000;
  localparam logic [63:0] RID    = 64'h3C5A96E1F00D4B27; // arbitrary value
  logic                sys_clk = 1'b0;
  logic                resetn  = 1'b0;
  wire logic           line_in;
  logic                line_out;
  logic                line_oe;
  logic                selected;
  swsc_pkg::swsc_cnt_t counter_state;
  int                  err_count = 0;
  int                  n_tests = 0;
  int                  m_val = 0;
  bit                  m_wr, m_pset, m_lock;
  logic [7:0]          exp_q[$];
  always #2 sys_clk = ~sys_clk;
  swsc_top #(.PU_CYC(PU_CYC), .ROM_ID(RID)) u_dut (
    .sys_clk(sys_clk), .resetn(resetn), .line_in(line_in),
    .line_out(line_out), .line_oe(line_oe),
    .counter_state(counter_state), .selected(selected));
  swsc_master u_mst (.sys_clk(sys_clk), .line_oe(line_oe),
    .bus_line(line_in));
  task automatic chk(input string w, input logic [23:0] e, g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] d);
    c = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    return c;
  endfunction
  // model the reply, then run one whole transaction on the bus
  task automatic txn(input logic [7:0] rom, fn, input logic [23:0] prm,
                     input int np, input bit bad, ign);
    logic        p;
    logic        ok;
    logic [7:0]  b;
    logic [15:0] c;
    exp_q = {};
    ok = 1'b0;
    if (ign) exp_q = {8'hFF, 8'hFF, 8'hFF};
    else if (bad) exp_q.push_back(swsc_pkg::STS_CRC_ERR);
    else begin
      case (fn)
        swsc_pkg::FN_WRITE:   ok = !m_wr && !m_lock;
        swsc_pkg::FN_DEC:     ok = m_wr && m_val > 0;
        swsc_pkg::FN_PROTECT: ok = !m_pset;
        default:              ok = 1'b1;
      endcase
      exp_q.push_back(ok ? swsc_pkg::STS_OK : swsc_pkg::STS_FAIL);
    end
    if (ok && fn == swsc_pkg::FN_WRITE) m_val = int'(prm[23:7]);
    if (ok && fn == swsc_pkg::FN_WRITE) m_wr = 1'b1;
    if (ok && fn == swsc_pkg::FN_DEC) m_val--;
    if (ok && fn == swsc_pkg::FN_PROTECT) m_lock = prm[0];
    // the user byte only counts as set once it leaves its reset value
    if (ok && fn == swsc_pkg::FN_PROTECT)
      m_pset = prm[7:0] != swsc_pkg::PROT_RESET;
    for (int i = 0; ok && fn == swsc_pkg::FN_READ && i < 3; i++)
      exp_q.push_back(8'(m_val >> 8 * i));
    u_mst.bus_reset(p);
    chk("presence", 1, p);
    u_mst.wbyte(rom);
    for (int i = 0; rom == swsc_pkg::ROM_MATCH && i < 8; i++)
      u_mst.wbyte(RID[8*i+:8]);
    u_mst.wbyte(swsc_pkg::CMD_START);
    u_mst.wbyte(fn);
    c = crc_step(swsc_pkg::CRC_INIT, fn);
    for (int i = 0; i < np; i++) begin
      u_mst.wbyte(prm[8*i+:8]);
      c = crc_step(c, prm[8*i+:8]);
    end
    if (bad) c = ~c;
    u_mst.wbyte(c[7:0]);
    u_mst.wbyte(c[15:8]);
    c = swsc_pkg::CRC_INIT;
    foreach (exp_q[i]) begin
      u_mst.rbyte(b);
      chk("reply byte", exp_q[i], b);
      c = crc_step(c, exp_q[i]);
    end
    for (int i = 0; !ign && i < 2; i++) begin
      u_mst.rbyte(b);
      chk("reply crc", c[8*i+:8], b);
    end
    chk("counter", {m_wr, m_val[16:0]}, counter_state);
    $display("test done: selection %h function %h", rom, fn);
  endtask
  initial begin
    logic       p, a, n;
    logic [7:0] b;
    void'($urandom(32'h448A));
    repeat (4) @(posedge sys_clk);
    #1 resetn = 1'b1;
    // presence must appear on its own after reset release
    for (int i = 0; i < PU_CYC + 1000 && !line_oe; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk("power-up presence", 1, line_oe);
    if (!line_oe) wrap_up();
    u_mst.hold(2 * PU_CYC);
    u_mst.wbyte(swsc_pkg::CMD_START);
    u_mst.wbyte(8'($urandom));
    u_mst.rbyte(b);
    chk("reply before bus reset", 8'hFF, b);
    u_mst.bus_reset(p);
    u_mst.wbyte(swsc_pkg::ROM_READ);
    for (int i = 0; i < 8; i++) begin
      u_mst.rbyte(b);
      chk("id byte", RID[8*i+:8], b);
    end
    chk("selected", 1, selected);
    u_mst.bus_reset(p);
    u_mst.wbyte(swsc_pkg::ROM_SEARCH);
    u_mst.rbit(a);
    u_mst.rbit(n);
    chk("search bit pair", {RID[0], ~RID[0]}, {a, n});
    u_mst.wbit(~RID[0]);
    u_mst.wbyte(swsc_pkg::CMD_START);
    u_mst.rbyte(b);
    chk("reply after lost search", 8'hFF, b);
    $display("test done: selection commands");
    txn(swsc_pkg::ROM_SKIP, swsc_pkg::FN_DEC, 0, 0, 0, 0);
    chk("selected", 0, selected);
    txn(swsc_pkg::ROM_RESUME, swsc_pkg::FN_READ, 0, 0, 0, 1);
    txn(swsc_pkg::ROM_MATCH, swsc_pkg::FN_PROTECT, 0, 1, 0, 0);
    chk("selected", 1, selected);
    txn(swsc_pkg::ROM_RESUME, swsc_pkg::FN_WRITE,
        {17'(1 + $urandom % 2), 7'h00}, 3, 0, 0);
    txn(swsc_pkg::ROM_SKIP, swsc_pkg::FN_WRITE, 24'hFFFF80, 3, 0, 0);
    txn(swsc_pkg::ROM_SKIP, swsc_pkg::FN_PROTECT, 1, 1, 0, 0);
    txn(swsc_pkg::ROM_SKIP, swsc_pkg::FN_DEC, 0, 0, 1, 0);
    txn(swsc_pkg::ROM_SKIP, swsc_pkg::FN_READ, 0, 0, 0, 0);
    repeat (m_val + 1)
      txn(swsc_pkg::ROM_SKIP, swsc_pkg::FN_DEC, 0, 0, 0, 0);
    resetn = 1'b0;
    u_mst.hold(4);
    chk("counter after reset", 0, counter_state);
    chk("selected after reset", 0, selected);
    $display("test done: reset in mid run");
    wrap_up();
  end
endmodule
bind swsc_top swsc_monitor #(.PU_CYC(PU_CYC)) u_mon (
  .sys_clk(sys_clk), .resetn(resetn), .line_in(line_in),
  .line_out(line_out), .line_oe(line_oe),
  .counter_state(counter_state), .selected(selected));
`default_nettype wire
